// file: ppfm_map.svh
`ifndef PPFM_MAP_SVH
`define PPFM_MAP_SVH

// Register byte offsets on the plain register port
`define PPFM_A_PORT_LAST 8'h0b
`define PPFM_A_PE_HI 8'h10
`define PPFM_A_PF_LO 8'h11
`define PPFM_A_PG_LO 8'h12
`define PPFM_A_PG_HI 8'h13
`define PPFM_A_PH_LO 8'h14
`define PPFM_A_PH_HI 8'h15
`define PPFM_A_ISRC 8'h16
`define PPFM_A_WAKE_EN 8'h17
`define PPFM_A_BITOP 8'h18

// Reset values
`define PPFM_RST_PORT 8'hff
`define PPFM_RST_SEL 8'h00
`define PPFM_RST_ISRC 6'h00
`define PPFM_RST_WAKE_EN 8'h00
`define PPFM_RST_PREV 8'hff

// Select codes
`define PPFM_CODE_ALT 2'b10
`define PPFM_CODE_SEG 2'b11

// Port indices within the port arrays
`define PPFM_PA 0
`define PPFM_PB 1
`define PPFM_PE 2
`define PPFM_PF 3
`define PPFM_PG 4
`define PPFM_PH 5
`define PPFM_NPORT 6

// Managed pin index bases (pin index = base + bit)
`define PPFM_E_BASE 0
`define PPFM_F_BASE 8
`define PPFM_G_BASE 16
`define PPFM_G_HI_BASE 20
`define PPFM_H_BASE 24
`define PPFM_H_HI_BASE 28
`define PPFM_PE4_PIN 4
`define PPFM_OSC_IN_PIN 8
`define PPFM_OSC_OUT_PIN 9
`define PPFM_OSC_PINS 2

// Input-source field positions and candidate pins
`define PPFM_ISRC_SCS 4
`define PPFM_ISRC_PT 2
`define PPFM_ISRC_ST 0
`define PPFM_SCS_PIN0 2
`define PPFM_SCS_PIN1 3
`define PPFM_PT_PIN0 2
`define PPFM_PT_PIN1 4
`define PPFM_ST_PIN0 2
`define PPFM_ST_PIN1 3

// Bit set/clear command fields
`define PPFM_BOP_VAL 7
`define PPFM_BOP_BIT_MSB 6
`define PPFM_BOP_BIT_LSB 4
`define PPFM_BOP_TGT_MSB 3

`endif

// file: ppfm_pkg.sv
package ppfm_pkg;

   typedef enum logic [1:0] {
      PPFM_IO  = 2'b00,
      PPFM_KEY = 2'b01,
      PPFM_SEG = 2'b10,
      PPFM_OSC = 2'b11
   } ppfm_func_t;

   typedef ppfm_func_t [31:0] ppfm_funcs_t;
   typedef logic [5:0][7:0] ppfm_ports_t;

   typedef struct packed {
      logic [7:0] pe_hi;
      logic [7:0] pf_lo;
      logic [7:0] pg_lo;
      logic [7:0] pg_hi;
      logic [7:0] ph_lo;
      logic [7:0] ph_hi;
      logic [5:0] isrc;
   } ppfm_sel_t;

   typedef struct packed {
      ppfm_funcs_t func;
   } ppfm_dec_st_t;

   typedef struct packed {
      logic [7:0] prev;
      logic wake;
   } ppfm_wake_st_t;

   typedef struct packed {
      ppfm_ports_t pdat;
      ppfm_ports_t pdir;
      ppfm_sel_t sel;
      logic [7:0] wake_en;
      logic [7:0] rdata;
      ppfm_ports_t pad;
      ppfm_ports_t pad_oe_n;
      logic [31:0] touch_en;
      logic osc_in_en;
      logic osc_out_en;
      logic serial_chip_select_input;
      logic periodic_timer_capture_input;
      logic standard_timer_capture_input;
   } ppfm_st_t;

endpackage

// file: ppfm_decode.sv
`timescale 1ns/1ps
`include "ppfm_map.svh"

module ppfm_decode
   import ppfm_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire ppfm_sel_t sel_i,
   output ppfm_funcs_t func_o
);

   ppfm_dec_st_t q;
   ppfm_dec_st_t d;

   function automatic ppfm_func_t pick(input logic [1:0] code,
                                       input ppfm_func_t alt,
                                       input logic seg_ok);
      if (code == `PPFM_CODE_ALT) begin
         pick = alt;
      end else if (code == `PPFM_CODE_SEG && seg_ok) begin
         pick = PPFM_SEG;
      end else begin
         pick = PPFM_IO;
      end
   endfunction

   always_comb begin
      d = q;
      if (ce_i) begin
         d.func = ppfm_funcs_t'({32{PPFM_IO}});
         d.func[`PPFM_E_BASE + `PPFM_PE4_PIN] =
            pick(sel_i.pe_hi[1:0], PPFM_KEY, 1'b1);
         for (int i = 0; i < 4; i++) begin
            // Only the two low F pins carry the crystal
            d.func[`PPFM_F_BASE + i] = pick(sel_i.pf_lo[2*i +: 2],
               (i < `PPFM_OSC_PINS) ? PPFM_OSC : PPFM_IO, 1'b1);
            d.func[`PPFM_G_BASE + i] =
               pick(sel_i.pg_lo[2*i +: 2], PPFM_KEY, 1'b1);
            d.func[`PPFM_G_HI_BASE + i] =
               pick(sel_i.pg_hi[2*i +: 2], PPFM_KEY, 1'b0);
            d.func[`PPFM_H_BASE + i] =
               pick(sel_i.ph_lo[2*i +: 2], PPFM_IO, 1'b1);
            d.func[`PPFM_H_HI_BASE + i] =
               pick(sel_i.ph_hi[2*i +: 2], PPFM_IO, 1'b1);
         end
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         q <= '{func: ppfm_funcs_t'({32{PPFM_IO}})};
      end else begin
         q <= d;
      end
   end

   assign func_o = q.func;

endmodule

// file: ppfm_wake.sv
`timescale 1ns/1ps
`include "ppfm_map.svh"

module ppfm_wake
   import ppfm_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire logic sleep_i,
   input wire logic [7:0] pa_i,
   input wire logic [7:0] wake_en_i,
   output logic wake_o
);

   ppfm_wake_st_t q;
   ppfm_wake_st_t d;

   always_comb begin
      d = q;
      if (ce_i) begin
         d.prev = pa_i;
         // Falling edge on any enabled pin while asleep
         d.wake = sleep_i && |(wake_en_i & q.prev & ~pa_i);
      end
   end

   // Previous levels reset high so a pin held low at reset counts as an edge
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         q <= '{prev: `PPFM_RST_PREV, wake: 1'b0};
      end else begin
         q <= d;
      end
   end

   assign wake_o = q.wake;

endmodule

// file: ppfm_top.sv
`timescale 1ns/1ps
`include "ppfm_map.svh"

// Behaviour
// - Port E bit 4 select gives I/O for 00 and 01, touch key for 10, LCD segment for 11.
// - Port F bits 3 and 2 stay I/O for 00, 01, 10 and become LCD segments for 11.
// - Port F bit 1 gives I/O for 00 and 01, crystal output for 10, LCD segment for 11.
// - Port F bit 0 gives I/O for 00 and 01, crystal input for 10, LCD segment for 11.
// - Port G bits 3..0 give I/O for 00 and 01, touch keys for 10, LCD segments for 11.
// - Port G bits 7..4 become touch keys only for 10 and stay I/O otherwise.
// - Port H bits 3..0 stay I/O for 00, 01, 10 and become LCD segments for 11.
// - Port H bits 7..4 stay I/O for 00, 01, 10 and become LCD segments for 11.
// - Source bits 5..4 feed chip select from port A bit 2 (00, 10) or bit 3 (01, 11).
// - Source bits 3..2 feed periodic capture from port B bit 2 (00, 10) or bit 4 (01, 11).
// - Source bits 1..0 feed standard capture from port E bit 2 (00) or bit 3 (11).
// - Source register bits 7 and 6 ignore writes and read as zero.
// - Reset sets every port data and direction register to all ones.
// - A pin switched to output drives high unless its data bit was written first.
// - A bit set or clear reads the whole port, changes one bit and writes it all back.
// - While asleep, a falling edge on an enabled port A pin wakes the device.
module ppfm_top
   import ppfm_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   input wire ppfm_ports_t pin_i,
   input wire logic [31:0] seg_data_i,
   input wire logic sleep_i,
   output ppfm_ports_t pad_o,
   output ppfm_ports_t pad_oe_n_o,
   output logic [31:0] touch_en_o,
   output logic crystal_input_pin_en_o,
   output logic crystal_output_pin_en_o,
   output logic serial_chip_select_input_o,
   output logic periodic_timer_capture_input_o,
   output logic standard_timer_capture_input_o,
   output logic wake_o
);

   ppfm_st_t q;
   ppfm_st_t d;
   ppfm_funcs_t func;

   // Port view as software sees it: pin level on inputs, latch on outputs
   function automatic logic [7:0] port_view(input ppfm_ports_t dat,
                                            input ppfm_ports_t dir,
                                            input ppfm_ports_t pins,
                                            input logic [3:0] a);
      logic [2:0] idx;
      idx = a[3:1];
      if (a[0]) begin
         port_view = dir[idx];
      end else begin
         port_view = (dir[idx] & pins[idx]) | (~dir[idx] & dat[idx]);
      end
   endfunction

   ppfm_decode u_decode (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .ce_i(ce_i),
      .sel_i(q.sel),
      .func_o(func)
   );

   ppfm_wake u_wake (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .ce_i(ce_i),
      .sleep_i(sleep_i),
      .pa_i(pin_i[`PPFM_PA]),
      .wake_en_i(q.wake_en),
      .wake_o(wake_o)
   );

   always_comb begin
      logic [3:0] tgt;
      logic [2:0] bsel;
      logic [7:0] rmw;
      ppfm_func_t f;
      tgt = wdata_i[`PPFM_BOP_TGT_MSB:0];
      bsel = wdata_i[`PPFM_BOP_BIT_MSB:`PPFM_BOP_BIT_LSB];
      rmw = 8'h00;
      f = PPFM_IO;
      d = q;
      if (ce_i) begin
         // Register writes
         if (wr_i) begin
            if (addr_i <= `PPFM_A_PORT_LAST) begin
               if (addr_i[0]) begin
                  d.pdir[addr_i[3:1]] = wdata_i;
               end else begin
                  d.pdat[addr_i[3:1]] = wdata_i;
               end
            end else begin
               case (addr_i)
                  `PPFM_A_PE_HI: d.sel.pe_hi = wdata_i;
                  `PPFM_A_PF_LO: d.sel.pf_lo = wdata_i;
                  `PPFM_A_PG_LO: d.sel.pg_lo = wdata_i;
                  `PPFM_A_PG_HI: d.sel.pg_hi = wdata_i;
                  `PPFM_A_PH_LO: d.sel.ph_lo = wdata_i;
                  `PPFM_A_PH_HI: d.sel.ph_hi = wdata_i;
                  `PPFM_A_ISRC: d.sel.isrc = wdata_i[5:0];
                  `PPFM_A_WAKE_EN: d.wake_en = wdata_i;
                  `PPFM_A_BITOP: begin
                     // Targets beyond the port registers are ignored
                     if ({4'h0, tgt} <= `PPFM_A_PORT_LAST) begin
                        rmw = port_view(q.pdat, q.pdir, pin_i, tgt);
                        rmw[bsel] = wdata_i[`PPFM_BOP_VAL];
                        if (tgt[0]) begin
                           d.pdir[tgt[3:1]] = rmw;
                        end else begin
                           d.pdat[tgt[3:1]] = rmw;
                        end
                     end
                  end
                  default: ;
               endcase
            end
         end

         // Read data stand for exactly one enabled cycle
         d.rdata = 8'h00;
         if (rd_i) begin
            if (addr_i <= `PPFM_A_PORT_LAST) begin
               d.rdata = port_view(q.pdat, q.pdir, pin_i, addr_i[3:0]);
            end else begin
               case (addr_i)
                  `PPFM_A_PE_HI: d.rdata = q.sel.pe_hi;
                  `PPFM_A_PF_LO: d.rdata = q.sel.pf_lo;
                  `PPFM_A_PG_LO: d.rdata = q.sel.pg_lo;
                  `PPFM_A_PG_HI: d.rdata = q.sel.pg_hi;
                  `PPFM_A_PH_LO: d.rdata = q.sel.ph_lo;
                  `PPFM_A_PH_HI: d.rdata = q.sel.ph_hi;
                  `PPFM_A_ISRC: d.rdata = {2'b00, q.sel.isrc};
                  `PPFM_A_WAKE_EN: d.rdata = q.wake_en;
                  default: d.rdata = 8'h00;
               endcase
            end
         end

         // Pad drive; direction bit 1 means input, so it is the active-low enable
         for (int p = 0; p < `PPFM_NPORT; p++) begin
            for (int b = 0; b < 8; b++) begin
               if (p >= `PPFM_PE) begin
                  f = func[(p - `PPFM_PE) * 8 + b];
               end else begin
                  f = PPFM_IO;
               end
               case (f)
                  PPFM_SEG: begin
                     d.pad[p][b] = seg_data_i[(p - `PPFM_PE) * 8 + b];
                     d.pad_oe_n[p][b] = 1'b0;
                  end
                  PPFM_KEY, PPFM_OSC: begin
                     // Analog functions: pad released
                     d.pad[p][b] = 1'b0;
                     d.pad_oe_n[p][b] = 1'b1;
                  end
                  default: begin
                     d.pad[p][b] = q.pdat[p][b];
                     d.pad_oe_n[p][b] = q.pdir[p][b];
                  end
               endcase
            end
         end
         for (int k = 0; k < 32; k++) begin
            d.touch_en[k] = (func[k] == PPFM_KEY);
         end
         d.osc_in_en = (func[`PPFM_OSC_IN_PIN] == PPFM_OSC);
         d.osc_out_en = (func[`PPFM_OSC_OUT_PIN] == PPFM_OSC);

         // Input-source routing; bit 0 of a field decides, bit 1 for standard capture
         d.serial_chip_select_input = q.sel.isrc[`PPFM_ISRC_SCS] ?
            pin_i[`PPFM_PA][`PPFM_SCS_PIN1] :
            pin_i[`PPFM_PA][`PPFM_SCS_PIN0];
         d.periodic_timer_capture_input = q.sel.isrc[`PPFM_ISRC_PT] ?
            pin_i[`PPFM_PB][`PPFM_PT_PIN1] :
            pin_i[`PPFM_PB][`PPFM_PT_PIN0];
         // Ambiguous codes settled by the upper bit: 01 keeps bit 2
         d.standard_timer_capture_input = q.sel.isrc[`PPFM_ISRC_ST + 1] ?
            pin_i[`PPFM_PE][`PPFM_ST_PIN1] :
            pin_i[`PPFM_PE][`PPFM_ST_PIN0];
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         q.pdat <= {`PPFM_NPORT{`PPFM_RST_PORT}};
         q.pdir <= {`PPFM_NPORT{`PPFM_RST_PORT}};
         q.sel <= '{pe_hi: `PPFM_RST_SEL, pf_lo: `PPFM_RST_SEL,
                    pg_lo: `PPFM_RST_SEL, pg_hi: `PPFM_RST_SEL,
                    ph_lo: `PPFM_RST_SEL, ph_hi: `PPFM_RST_SEL,
                    isrc: `PPFM_RST_ISRC};
         q.wake_en <= `PPFM_RST_WAKE_EN;
         q.rdata <= 8'h00;
         q.pad <= {`PPFM_NPORT{`PPFM_RST_PORT}};
         q.pad_oe_n <= {`PPFM_NPORT{`PPFM_RST_PORT}};
         q.touch_en <= 32'h0000_0000;
         q.osc_in_en <= 1'b0;
         q.osc_out_en <= 1'b0;
         q.serial_chip_select_input <= 1'b0;
         q.periodic_timer_capture_input <= 1'b0;
         q.standard_timer_capture_input <= 1'b0;
      end else begin
         q <= d;
      end
   end

   assign rdata_o = q.rdata;
   assign pad_o = q.pad;
   assign pad_oe_n_o = q.pad_oe_n;
   assign touch_en_o = q.touch_en;
   assign crystal_input_pin_en_o = q.osc_in_en;
   assign crystal_output_pin_en_o = q.osc_out_en;
   assign serial_chip_select_input_o = q.serial_chip_select_input;
   assign periodic_timer_capture_input_o = q.periodic_timer_capture_input;
   assign standard_timer_capture_input_o = q.standard_timer_capture_input;

endmodule

// file: ppfm_pins.sv
`timescale 1ns/1ps
module ppfm_pins
   import ppfm_pkg::*;
(
   input wire ppfm_ports_t pad_i,
   input wire ppfm_ports_t oe_n_i,
   input wire ppfm_ports_t ext_i,
   output ppfm_ports_t pin_o
);
   // A driven pin shows its pad, a released one the board level
   assign pin_o = (pad_i & ~oe_n_i) | (ext_i & oe_n_i);
endmodule

// file: ppfm_top_assertions.sv
`timescale 1ns/1ps
module ppfm_chk
   import ppfm_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [7:0] rdata_o,
   input wire ppfm_ports_t pin_i,
   input wire logic sleep_i,
   input wire ppfm_ports_t pad_o,
   input wire ppfm_ports_t pad_oe_n_o,
   input wire logic [31:0] touch_en_o,
   input wire logic serial_chip_select_input_o,
   input wire logic standard_timer_capture_input_o,
   input wire logic wake_o
);
   logic [5:0] isrc_q;
   logic [7:0] wen_q;
   logic [3:0] keyw;
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         isrc_q <= 6'h00;
         wen_q <= 8'h00;
      end else if (ce_i && wr_i && addr_i == 8'h16) begin
         isrc_q <= wdata_i[5:0];
      end else if (ce_i && wr_i && addr_i == 8'h17) begin
         wen_q <= wdata_i;
      end
   end
   always_comb begin
      for (int j = 0; j < 4; j++) begin
         keyw[j] = wdata_i[2*j+:2] == 2'b10;
      end
   end
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);
   isrc_rsv_a: assert property (
      ce_i && rd_i && addr_i == 8'h16 |=> rdata_o == {2'b00, isrc_q})
      else $error("source register read wrong");
   cs_route_a: assert property (
      ce_i && !(wr_i && addr_i == 8'h16) |=> serial_chip_select_input_o
      == $past(isrc_q[4] ? pin_i[0][3] : pin_i[0][2]))
      else $error("chip select routed wrong");
   st_route_a: assert property (
      ce_i && !(wr_i && addr_i == 8'h16) |=> standard_timer_capture_input_o
      == $past(isrc_q[1] ? pin_i[2][3] : pin_i[2][2]))
      else $error("standard capture routed wrong");
   wake_go_a: assert property (
      ce_i && $past(ce_i) && sleep_i &&
      |(wen_q & $past(pin_i[0]) & ~pin_i[0]) |=> wake_o)
      else $error("no wake on enabled fall");
   wake_quiet_a: assert property (ce_i && !sleep_i |=> !wake_o)
      else $error("wake while awake");
   key_pad_a: assert property (
      (touch_en_o & (pad_o[5:2] | ~pad_oe_n_o[5:2])) == 32'h0)
      else $error("touch pin driven");
   key_pins_a: assert property ((touch_en_o & ~32'h00ff0010) == 32'h0)
      else $error("touch on wrong pin");
   glo_key_a: assert property (
      ce_i && wr_i && addr_i == 8'h12 ##1 ce_i [*2]
      |=> touch_en_o[19:16] == $past(keyw, 3))
      else $error("port g low touch wrong");
endmodule
bind ppfm_top ppfm_chk u_chk (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
   .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
   .rd_i(rd_i), .rdata_o(rdata_o), .pin_i(pin_i), .sleep_i(sleep_i),
   .pad_o(pad_o), .pad_oe_n_o(pad_oe_n_o), .touch_en_o(touch_en_o),
   .serial_chip_select_input_o(serial_chip_select_input_o),
   .standard_timer_capture_input_o(standard_timer_capture_input_o),
   .wake_o(wake_o));

// file: tb_port_pin_function_mux.sv
`timescale 1ns/1ps
module tb_port_pin_function_mux;
   import ppfm_pkg::*;
   logic mclk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic sleep_i = 1'b0;
   logic ce = 1'b1;
   logic rd_d = 1'b0;
   logic [7:0] addr_i = 8'h00;
   logic [7:0] wdata_i = 8'h00;
   logic [7:0] rdata_o;
   logic [31:0] lcd_segment_output = 32'h0;
   logic [31:0] rs = 32'hef0b;
   logic [31:0] touch;
   ppfm_ports_t ext = '1;
   ppfm_ports_t pin, pad, oe_n;
   logic [7:0] q[$];
   logic xi, xo, cs, pt, st, wake;
   int mismatches = 0;
   int checked = 0;
   always #20 mclk_i = ~mclk_i;
   ppfm_top u_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(ce),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
      .rdata_o(rdata_o), .pin_i(pin), .seg_data_i(lcd_segment_output), .sleep_i(sleep_i),
      .pad_o(pad), .pad_oe_n_o(oe_n), .touch_en_o(touch),
      .crystal_input_pin_en_o(xi), .crystal_output_pin_en_o(xo),
      .serial_chip_select_input_o(cs), .periodic_timer_capture_input_o(pt),
      .standard_timer_capture_input_o(st), .wake_o(wake));
   ppfm_pins u_pins (.pad_i(pad), .oe_n_i(oe_n), .ext_i(ext), .pin_o(pin));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         mismatches++;
         $display("wrong value at %0t: %h, expected %h", $time, s, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge mclk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge mclk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      q.push_back(e);
      @(posedge mclk_i);
      rd_i <= 1'b0;
   endtask
   task automatic close_out();
      $display("checked %0d, mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   always @(posedge mclk_i) rd_d <= rd_i;
   // Read data stand only one cycle, so look mid-cycle
   always @(negedge mclk_i) begin
      if (rd_d) begin
         chk(rdata_o, q.pop_front());
      end
   end
   initial begin
      repeat (5000) @(posedge mclk_i);
      mismatches++;
      close_out();
   end
   initial begin
      logic [7:0] d, e;
      logic [31:0] m;
      repeat (20) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      for (int p = 0; p < 6; p++) begin
         rs = lfsr(rs);
         d = rs[7:0];
         rd(8'(2*p+1), 8'hff);
         wr(8'(2*p+1), 8'h00);
         // Pads follow a direction write one edge later
         @(posedge mclk_i);
         #1;
         chk(pad[p], 8'hff);
         chk(oe_n[p], 8'h00);
         wr(8'(2*p), d);
         rd(8'(2*p), d);
         wr(8'(2*p+1), 8'hff);
      end
      for (int a = 16; a < 25; a++) rd(8'(a), 8'h00);
      rd(8'h1f, 8'h00);
      ext[2] <= rs[15:8];
      wr(8'h05, 8'hf0);
      wr(8'h04, d);
      wr(8'h18, {~d[1], 3'd1, 4'h4});
      // Input bits take the pin level when written back
      e = {rs[15:12], d[3:2], ~d[1], d[0]};
      rd(8'h04, e);
      wr(8'h05, 8'h00);
      #1;
      chk(pad[2], e);
      wr(8'h05, 8'hff);
      for (int c = 0; c < 4; c++) begin
         rs = lfsr(rs);
         lcd_segment_output <= rs;
         for (int a = 16; a < 22; a++) wr(8'(a), {4{2'(c)}});
         rd(8'h11, {4{2'(c)}});
         #1;
         m = (c == 3) ? 32'hff0f0f10 : 32'h0;
         chk(oe_n[5:2], ~m);
         chk(pad[5:2] & m, lcd_segment_output & m);
         chk(touch, (c == 2) ? 32'h00ff0010 : 32'h0);
         chk({xi, xo}, (c == 2) ? 2'b11 : 2'b00);
      end
      for (int c = 0; c < 4; c++) begin
         wr(8'h16, {2'b11, {3{2'(c)}}});
         rd(8'h16, {2'b00, {3{2'(c)}}});
         rs = lfsr(rs);
         ext[0] <= rs[7:0];
         ext[1] <= rs[15:8];
         ext[2] <= rs[23:16];
         repeat (2) @(posedge mclk_i);
         #1;
         chk(cs, c[0] ? rs[3] : rs[2]);
         chk(pt, c[0] ? rs[12] : rs[10]);
         chk(st, c[1] ? rs[19] : rs[18]);
      end
      wr(8'h17, 8'h04);
      ext[0] <= 8'hff;
      sleep_i <= 1'b1;
      @(posedge mclk_i);
      ext[0] <= 8'hf7;
      @(posedge mclk_i);
      #1;
      chk(wake, 1'b0);
      @(posedge mclk_i);
      ext[0] <= 8'hf3;
      @(posedge mclk_i);
      #1;
      chk(wake, 1'b1);
      // Strobes are ignored while the clock enable is low
      @(posedge mclk_i);
      ce <= 1'b0;
      wr(8'h17, 8'hff);
      ce <= 1'b1;
      rd(8'h17, 8'h04);
      wr(8'h18, 8'h0b);
      rd(8'h0b, 8'hfe);
      close_out();
   end
endmodule
